//--- core/icsr_regs.svh
// What this block does
// - Write command copies access data into selected CSR, then clears write bit.
// - Core select picks core offset; otherwise offset within the selected user bank.
// - Host writes ignore user bank write permits; permits gate serial bus only.
// - Host writes into configuration ROM region are rejected as unsupported.
// - Unsupported write sets access error, clears write bit, changes nothing.
// - Read command loads CSR into data field, clears read bit, sets received flag.
// - ROM reads quadlet only; user reads quadlet or block up to 8; else error.
// - Lock command is compare-swap: equal compare writes the swap value.
// - Failed compare or unsupported target leaves CSR alone and sets access error.
// - Lock returns old CSR value, clears lock bit, sets received flag.
// - Bus write or lock with request irq pending aborts host command, sets busy.
// - User space holds 128 bytes, split into up to four banks.
// - Bank size counts quadlets; size zero disables the bank.
// - Per-bank write, read and swap permits gate serial-bus access.
// - Bank base is 28 low bits under fixed upper bits 0x000FFFFF.
// - User block request longer than 8 answers as a type error.
// - Core area wins over any overlapping user bank.
// - One STATE register; clear alias clears ones, set alias sets ones.
// - Setting link-off through set alias raises the link-off flag.
// - Cycle-master bit follows root and control; alias writes with that bit one raise its flag.
// - State field reads 1 from bus reset to self-ID done; host cannot write it.
// - Bus write to clear alias clears only fields written as one.
// - Bus write to reset-start raises command reset and applies reset values.
`ifndef ICSR_REGS_SVH
`define ICSR_REGS_SVH

// ============================================================
// Host register selectors
`define ICSR_SEL_CMD 2'h0
`define ICSR_SEL_DATA 2'h1
`define ICSR_SEL_SWAP 2'h2

// ============================================================
// Core area offsets
`define ICSR_UPPER 20'hfffff
`define ICSR_OFF_STCLR 28'h0000000
`define ICSR_OFF_STSET 28'h0000004
`define ICSR_OFF_RST 28'h000000c
`define ICSR_ROM_LO 28'h0000400
`define ICSR_CORE_END 28'h0000800

// ============================================================
// User space sizing
`define ICSR_US_BYTES 128
`define ICSR_US_QUADS (`ICSR_US_BYTES / 4)
`define ICSR_MAX_BLK 8'h08

// ============================================================
// STATE fields and reset values
`define ICSR_ST_LINKOFF 9
`define ICSR_ST_CMSTR 8
`define ICSR_ST_INIT 32'h00000000
`define ICSR_ST_SB_MASK 32'h00008700
`define ICSR_ST_HOST_MASK 32'hfffffffc
`define ICSR_ST_RST_KEEP 32'h00000300
`define ICSR_ST_RST_SET 32'h00008000

`endif

//--- core/icsr_pkg.sv
package icsr_pkg;

	typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE, OP_LOCK} icsr_op_t;
	typedef enum logic [2:0] {TG_NONE, TG_STCLR, TG_STSET, TG_RST, TG_ROM, TG_USER} icsr_tgt_t;
	typedef enum logic [1:0] {RC_COMPLETE, RC_TYPE_ERR, RC_ADDR_ERR} icsr_rcode_t;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} icsr_fsm_t;

	typedef struct packed {
		logic [8:0] rsvd;
		logic [3:0] read_len;
		logic [11:0] target_offset_field;
		logic [1:0] bank_select_field;
		logic core_area_select;
		logic busy;
		logic lock;
		logic read;
		logic write;
	} icsr_cmd_t;

	typedef struct packed {
		logic access_error_flag;
		logic read_data_received_flag;
		logic [31:0] access_data_field;
	} icsr_data_t;

	typedef struct packed {
		logic [27:0] bank_base_address;
		logic [5:0] bank_length_quadlets;
		logic bank_write_permit;
		logic bank_read_permit;
		logic bank_swap_permit;
	} icsr_bank_t;

	typedef struct packed {
		icsr_op_t op;
		logic [47:0] offset;
		logic [7:0] blk_len;
		logic [31:0] wdata;
		logic [31:0] arg;
	} icsr_sbreq_t;

	typedef struct packed {
		logic from_sb;
		icsr_op_t op;
		icsr_tgt_t tgt;
		icsr_rcode_t err;
		logic [4:0] uidx;
		logic [31:0] wdata;
		logic [31:0] arg;
	} icsr_ctx_t;

endpackage

//--- core/icsr_mem.sv
`timescale 1ns/1ps
module icsr_mem #(
	parameter int DW = 32,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic mclk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem_q [0:DEPTH-1];

	// Storage has no reset; contents are undefined until written
	always_ff @(posedge mclk_i)
	begin
		if (we_i)
			mem_q[waddr_i] <= wdata_i;
		rdata_o <= mem_q[raddr_i];
	end
endmodule // icsr_mem

//--- core/icsr_top.sv
`timescale 1ns/1ps
`include "icsr_regs.svh"
module icsr_top #(
	parameter int US_QUADS = `ICSR_US_QUADS,
	parameter int NBANK = 4
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic hreg_we_i,
	input wire logic [1:0] hreg_sel_i,
	input wire logic [31:0] hreg_wdata_i,
	input wire icsr_pkg::icsr_bank_t [NBANK-1:0] bank_cfg_i,
	input wire logic sb_req_i,
	input wire icsr_pkg::icsr_sbreq_t sb_reqd_i,
	input wire logic received_csr_request_irq_i,
	input wire logic bus_reset_i,
	input wire logic selfid_done_i,
	input wire logic is_root_i,
	input wire logic cycle_master_control_i,
	input wire logic [31:0] rom_rdata_i,
	output icsr_pkg::icsr_cmd_t cmd_reg_o,
	output icsr_pkg::icsr_data_t data_reg_o,
	output logic [31:0] swap_value_field_o,
	output logic [31:0] node_state_image_o,
	output logic [7:0] rom_addr_o,
	output logic sb_ready_o,
	output logic sb_ack_o,
	output icsr_pkg::icsr_rcode_t sb_rcode_o,
	output logic [31:0] sb_rdata_o,
	output logic linkoff_flag_o,
	output logic cmstr_flag_o,
	output logic command_reset_irq_o
);
	icsr_pkg::icsr_fsm_t fsm_q, fsm_d;
	icsr_pkg::icsr_ctx_t ctx_q, ctx_d;
	icsr_pkg::icsr_cmd_t cmd_q, cmd_d;
	icsr_pkg::icsr_data_t data_q, data_d;
	logic [31:0] swap_q, st_q, st_d;
	logic [7:0] rom_q;
	logic ack_q, lof_q, cmf_q, crst_q;
	icsr_pkg::icsr_rcode_t rc_q;
	logic [31:0] rdat_q;
	logic [31:0] mem_rdata;

	// ============================================================
	// Source selection
	wire host_pend = cmd_q.write | cmd_q.read | cmd_q.lock;
	wire idle = (fsm_q == icsr_pkg::ST_IDLE);
	// Bus requests wait for ready, also in the cycle after reset
	wire take_sb = idle & sb_req_i & sb_ready_o;
	wire take_host = idle & ~sb_req_i & host_pend;
	wire sb_wl = (sb_reqd_i.op == icsr_pkg::OP_WRITE) | (sb_reqd_i.op == icsr_pkg::OP_LOCK);
	wire abort_host = take_sb & sb_wl & received_csr_request_irq_i & host_pend;
	wire icsr_pkg::icsr_op_t host_op = cmd_q.write ? icsr_pkg::OP_WRITE :
		cmd_q.read ? icsr_pkg::OP_READ : icsr_pkg::OP_LOCK;
	wire icsr_pkg::icsr_op_t d_op = sb_req_i ? sb_reqd_i.op : host_op;
	wire [7:0] d_len = sb_req_i ? sb_reqd_i.blk_len : {4'h0, cmd_q.read_len};
	wire sb_upper_ok = (sb_reqd_i.offset[47:28] == `ICSR_UPPER);
	wire d_core = sb_req_i ? (sb_reqd_i.offset[27:0] < `ICSR_CORE_END) : cmd_q.core_area_select;
	wire [27:0] d_off = sb_req_i ? sb_reqd_i.offset[27:0] : {16'h0000, cmd_q.target_offset_field};

	// ============================================================
	// Bank layout and hit detection
	logic [6:0] bstart [0:NBANK];
	logic [NBANK-1:0] bhit;
	logic [5:0] brel [0:NBANK-1];
	assign bstart[0] = 7'h00;
	for (genvar k = 0; k < NBANK; k++)
	begin : g_bank
		wire [27:0] rel = d_off - bank_cfg_i[k].bank_base_address;
		wire [5:0] sz = bank_cfg_i[k].bank_length_quadlets;
		assign bstart[k+1] = bstart[k] + {1'b0, sz};
		assign brel[k] = rel[7:2];
		assign bhit[k] = (d_off >= bank_cfg_i[k].bank_base_address) && (rel[27:8] == 20'h00000)
			&& (rel[1:0] == 2'b00) && (rel[7:2] < sz);
	end

	logic [1:0] sb_bank;
	logic sb_any;
	always_comb
	begin
		sb_bank = 2'd0;
		sb_any = 1'b0;
		for (int k = NBANK - 1; k >= 0; k--)
		begin
			if (bhit[k])
			begin
				sb_bank = 2'(k);
				sb_any = 1'b1;
			end
		end
	end

	wire [1:0] u_bank = sb_req_i ? sb_bank : cmd_q.bank_select_field;
	wire [9:0] h_qidx = cmd_q.target_offset_field[11:2];
	wire h_inbank = (cmd_q.target_offset_field[1:0] == 2'b00) &&
		(h_qidx < {4'h0, bank_cfg_i[u_bank].bank_length_quadlets});
	wire u_hit = sb_req_i ? sb_any : h_inbank;
	wire [6:0] u_rel = sb_req_i ? {1'b0, brel[sb_bank]} : h_qidx[6:0];
	wire [6:0] u_idx7 = bstart[u_bank] + u_rel;
	wire u_ok = u_hit && (u_idx7 < 7'(US_QUADS));
	wire icsr_pkg::icsr_bank_t u_cfg = bank_cfg_i[u_bank];

	// ============================================================
	// Target and error decode
	wire icsr_pkg::icsr_tgt_t core_tgt = (d_off == `ICSR_OFF_STCLR) ? icsr_pkg::TG_STCLR :
		(d_off == `ICSR_OFF_STSET) ? icsr_pkg::TG_STSET :
		(d_off == `ICSR_OFF_RST) ? icsr_pkg::TG_RST :
		((d_off >= `ICSR_ROM_LO) && (d_off < `ICSR_CORE_END)) ? icsr_pkg::TG_ROM :
		icsr_pkg::TG_NONE;
	wire icsr_pkg::icsr_tgt_t d_tgt = (sb_req_i && !sb_upper_ok) ? icsr_pkg::TG_NONE :
		d_core ? core_tgt : (u_ok ? icsr_pkg::TG_USER : icsr_pkg::TG_NONE);
	wire is_rd = (d_op == icsr_pkg::OP_READ);
	wire is_wr = (d_op == icsr_pkg::OP_WRITE);
	wire is_lk = (d_op == icsr_pkg::OP_LOCK);
	wire rom_bad = !is_rd || (d_len != 8'h00);
	wire st_bad = is_lk || (d_len != 8'h00);
	wire usr_len_bad = (d_len > `ICSR_MAX_BLK);
	wire usr_perm_bad = sb_req_i && ((is_wr && !u_cfg.bank_write_permit) ||
		(is_rd && !u_cfg.bank_read_permit) || (is_lk && !u_cfg.bank_swap_permit));
	wire type_bad = (d_tgt == icsr_pkg::TG_ROM) ? rom_bad :
		((d_tgt == icsr_pkg::TG_STCLR) || (d_tgt == icsr_pkg::TG_STSET)) ? st_bad :
		(d_tgt == icsr_pkg::TG_RST) ? (!is_wr || !sb_req_i) :
		(d_tgt == icsr_pkg::TG_USER) ? (usr_len_bad || usr_perm_bad) : 1'b0;
	wire icsr_pkg::icsr_rcode_t d_err = (d_tgt == icsr_pkg::TG_NONE) ? icsr_pkg::RC_ADDR_ERR :
		type_bad ? icsr_pkg::RC_TYPE_ERR : icsr_pkg::RC_COMPLETE;

	// ============================================================
	// Execute stage values
	wire ok_x = (ctx_q.err == icsr_pkg::RC_COMPLETE);
	wire [31:0] old_val = (ctx_q.tgt == icsr_pkg::TG_USER) ? mem_rdata :
		(ctx_q.tgt == icsr_pkg::TG_ROM) ? rom_rdata_i :
		((ctx_q.tgt == icsr_pkg::TG_STCLR) || (ctx_q.tgt == icsr_pkg::TG_STSET)) ? st_q : 32'h0;
	wire exec = (fsm_q == icsr_pkg::ST_EXEC);
	wire x_wr = exec && ok_x && (ctx_q.op == icsr_pkg::OP_WRITE);
	wire cmp_eq = (old_val == ctx_q.arg);
	wire x_lk = exec && ok_x && (ctx_q.op == icsr_pkg::OP_LOCK) && cmp_eq;
	wire [31:0] new_val = (ctx_q.op == icsr_pkg::OP_LOCK) ? ctx_q.wdata : ctx_q.arg;
	wire mem_we = (x_wr || x_lk) && (ctx_q.tgt == icsr_pkg::TG_USER);
	wire [31:0] st_mask = ctx_q.from_sb ? `ICSR_ST_SB_MASK : `ICSR_ST_HOST_MASK;
	wire st_clr = x_wr && (ctx_q.tgt == icsr_pkg::TG_STCLR);
	wire st_set = x_wr && (ctx_q.tgt == icsr_pkg::TG_STSET);
	wire cmd_rst = x_wr && (ctx_q.tgt == icsr_pkg::TG_RST);
	wire [31:0] wmask = new_val & st_mask;

	icsr_mem #(.DW(32), .DEPTH(US_QUADS), .AW(5)) u_mem (
		.mclk_i(mclk_i),
		.we_i(mem_we),
		.waddr_i(ctx_q.uidx),
		.wdata_i(new_val),
		.raddr_i(ctx_q.uidx),
		.rdata_o(mem_rdata)
	);

	// ============================================================
	// Sequencer
	always_comb
	begin
		fsm_d = fsm_q;
		ctx_d = ctx_q;
		case (fsm_q)
			icsr_pkg::ST_IDLE:
			begin
				if (take_sb || take_host)
				begin
					fsm_d = icsr_pkg::ST_FETCH;
					ctx_d.from_sb = sb_req_i;
					ctx_d.op = d_op;
					ctx_d.tgt = d_tgt;
					ctx_d.err = d_err;
					ctx_d.uidx = u_idx7[4:0];
					ctx_d.wdata = sb_req_i ? sb_reqd_i.wdata : swap_q;
					ctx_d.arg = sb_req_i ? sb_reqd_i.arg : data_q.access_data_field;
				end
			end
			icsr_pkg::ST_FETCH: fsm_d = icsr_pkg::ST_EXEC;
			icsr_pkg::ST_EXEC: fsm_d = icsr_pkg::ST_IDLE;
			default: fsm_d = icsr_pkg::ST_IDLE;
		endcase
	end

	// ============================================================
	// Host command and data registers
	always_comb
	begin
		cmd_d = cmd_q;
		data_d = data_q;
		if (hreg_we_i && (hreg_sel_i == `ICSR_SEL_CMD))
		begin
			cmd_d = icsr_pkg::icsr_cmd_t'(hreg_wdata_i);
			cmd_d.busy = 1'b0;
			cmd_d.rsvd = 9'h000;
		end
		if (hreg_we_i && (hreg_sel_i == `ICSR_SEL_DATA))
		begin
			data_d.access_data_field = hreg_wdata_i;
			data_d.access_error_flag = 1'b0;
			data_d.read_data_received_flag = 1'b0;
		end
		if (abort_host)
		begin
			cmd_d.write = 1'b0;
			cmd_d.read = 1'b0;
			cmd_d.lock = 1'b0;
			cmd_d.busy = 1'b1;
		end
		if (exec && !ctx_q.from_sb)
		begin
			if (!ok_x || ((ctx_q.op == icsr_pkg::OP_LOCK) && !cmp_eq))
				data_d.access_error_flag = 1'b1;
			if (ctx_q.op != icsr_pkg::OP_WRITE)
			begin
				if (ok_x)
					data_d.access_data_field = old_val;
				data_d.read_data_received_flag = ok_x;
			end
			cmd_d.write = 1'b0;
			cmd_d.read = 1'b0;
			cmd_d.lock = 1'b0;
		end
	end

	// ============================================================
	// STATE register
	always_comb
	begin
		st_d = st_q;
		if (st_clr)
			st_d = st_q & ~wmask;
		if (st_set)
			st_d = st_q | wmask;
		if (bus_reset_i || cmd_rst)
			st_d = (st_q & `ICSR_ST_RST_KEEP) | `ICSR_ST_RST_SET;
		if (!is_root_i)
			st_d[`ICSR_ST_CMSTR] = 1'b0;
		else if (cycle_master_control_i)
			st_d[`ICSR_ST_CMSTR] = 1'b1;
		st_d[1] = 1'b0;
		if (bus_reset_i)
			st_d[0] = 1'b1;
		else if (selfid_done_i)
			st_d[0] = 1'b0;
		else
			st_d[0] = st_q[0];
	end

	// ============================================================
	// Flops
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			fsm_q <= icsr_pkg::ST_IDLE;
			ctx_q <= '0;
			cmd_q <= '0;
			data_q <= '0;
			swap_q <= 32'h0;
			st_q <= `ICSR_ST_INIT;
			rom_q <= 8'h00;
			sb_ready_o <= 1'b0;
			ack_q <= 1'b0;
			rc_q <= icsr_pkg::RC_COMPLETE;
			rdat_q <= 32'h0;
			lof_q <= 1'b0;
			cmf_q <= 1'b0;
			crst_q <= 1'b0;
		end
		else
		begin
			fsm_q <= fsm_d;
			ctx_q <= ctx_d;
			cmd_q <= cmd_d;
			data_q <= data_d;
			if (hreg_we_i && (hreg_sel_i == `ICSR_SEL_SWAP))
				swap_q <= hreg_wdata_i;
			st_q <= st_d;
			if (idle)
				rom_q <= d_off[9:2];
			sb_ready_o <= (fsm_d == icsr_pkg::ST_IDLE);
			ack_q <= exec && ctx_q.from_sb;
			if (exec)
			begin
				rc_q <= ctx_q.err;
				rdat_q <= old_val;
			end
			lof_q <= st_set && wmask[`ICSR_ST_LINKOFF];
			cmf_q <= (st_set || st_clr) && wmask[`ICSR_ST_CMSTR];
			crst_q <= cmd_rst;
		end
	end

	assign cmd_reg_o = cmd_q;
	assign data_reg_o = data_q;
	assign swap_value_field_o = swap_q;
	assign node_state_image_o = st_q;
	assign rom_addr_o = rom_q;
	assign sb_ack_o = ack_q;
	assign sb_rcode_o = rc_q;
	assign sb_rdata_o = rdat_q;
	assign linkoff_flag_o = lof_q;
	assign cmstr_flag_o = cmf_q;
	assign command_reset_irq_o = crst_q;
endmodule // icsr_top

//--- tb/icsr_top_sva.sv
`timescale 1ns/1ps
module icsr_top_sva (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic hreg_we_i,
	input wire logic [1:0] hreg_sel_i,
	input wire logic [31:0] hreg_wdata_i,
	input wire logic sb_req_i,
	input wire logic bus_reset_i,
	input wire logic selfid_done_i,
	input wire logic is_root_i,
	input wire logic cycle_master_control_i,
	input wire icsr_pkg::icsr_cmd_t cmd_reg_o,
	input wire icsr_pkg::icsr_data_t data_reg_o,
	input wire logic [31:0] node_state_image_o,
	input wire logic sb_ready_o,
	input wire logic sb_ack_o,
	input wire logic linkoff_flag_o,
	input wire logic command_reset_irq_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	// ==========
	// Bus handshake
	sequence sb_take;
		sb_req_i && sb_ready_o;
	endsequence
	sequence sb_answer;
		!sb_ready_o [*2] ##1 (sb_ack_o && sb_ready_o);
	endsequence
	sb_turn_a: assert property (sb_take |=> sb_answer)
		else $error("bus answer late");
	ack_cause_a: assert property (sb_ack_o |-> $past(sb_req_i && sb_ready_o, 3))
		else $error("ack without request");
	// ==========
	// Host read
	read_done_a: assert property (hreg_we_i && hreg_sel_i == 2'h0 && hreg_wdata_i[2:0] == 3'h2
		|=> cmd_reg_o.read ##[1:12] !cmd_reg_o.read)
		else $error("read bit stuck");
	read_flag_a: assert property ($fell(cmd_reg_o.read) && !cmd_reg_o.busy
		|-> data_reg_o.read_data_received_flag || data_reg_o.access_error_flag)
		else $error("read ended without flag");
	// ==========
	// STATE side effects
	linkoff_bit_a: assert property (linkoff_flag_o |-> node_state_image_o[9])
		else $error("linkoff flag without bit");
	cmstr_off_a: assert property (!is_root_i |=> !node_state_image_o[8])
		else $error("cmstr kept off root");
	cmstr_on_a: assert property (is_root_i && cycle_master_control_i |=> node_state_image_o[8])
		else $error("cmstr not set");
	state_busrst_a: assert property (bus_reset_i |=> node_state_image_o[1:0] == 2'h1)
		else $error("state field not one");
	state_hold_a: assert property ($changed(node_state_image_o[1:0])
		|-> $past(bus_reset_i) || $past(selfid_done_i))
		else $error("state field moved");
	cmd_reset_a: assert property (command_reset_irq_o |-> ##[0:1] node_state_image_o[15])
		else $error("gone not set");
endmodule // icsr_top_sva

//--- tb/icsr_host_bfm.sv
`timescale 1ns/1ps
module icsr_host_bfm (
	input wire logic mclk_i,
	input wire icsr_pkg::icsr_cmd_t cmd_reg_i,
	output logic hreg_we_o,
	output logic [1:0] hreg_sel_o,
	output logic [31:0] hreg_wdata_o
);
	initial
	begin
		hreg_we_o = 1'b0;
		hreg_sel_o = 2'h0;
		hreg_wdata_o = 32'h0;
	end
	// ==========
	// One register write
	task automatic put(input logic [1:0] sel, input logic [31:0] d);
		@(negedge mclk_i);
		hreg_we_o = 1'b1;
		hreg_sel_o = sel;
		hreg_wdata_o = d;
		@(negedge mclk_i);
		hreg_we_o = 1'b0;
		hreg_wdata_o = ~d;
	endtask
	task automatic issue(input logic [31:0] w, output logic ok);
		int n;
		ok = 1'b0;
		put(2'h0, w);
		for (n = 0; n < 40 && !ok; n++)
		begin
			@(negedge mclk_i);
			if (cmd_reg_i.busy === 1'b1)
				put(2'h0, w);
			else if (cmd_reg_i[2:0] === 3'h0)
				ok = 1'b1;
		end
	endtask
endmodule // icsr_host_bfm

//--- tb/icsr_top_tb.sv
`timescale 1ns/1ps
module icsr_top_tb;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic we, sb_req = 1'b0, irq = 1'b0, brst = 1'b0, sid = 1'b0, root = 1'b0, cmc = 1'b0;
	logic [1:0] sel;
	logic [31:0] wd, swp, st, sb_rdata;
	logic [7:0] rom_addr;
	icsr_pkg::icsr_bank_t [3:0] banks;
	icsr_pkg::icsr_sbreq_t sb_reqd = '0;
	icsr_pkg::icsr_cmd_t cmd;
	icsr_pkg::icsr_data_t dat;
	icsr_pkg::icsr_rcode_t rc;
	logic sb_ready, sb_ack, ok;
	logic lof, cmf, crst;
	int n_lof = 0, n_cmf = 0, n_crst = 0;
	int n_fail = 0;
	int checked = 0;
	always #10 mclk_i = ~mclk_i;
	// Pulses last one cycle, so one falling edge sees each
	always @(negedge mclk_i)
	begin
		if (lof === 1'b1)
			n_lof++;
		if (cmf === 1'b1)
			n_cmf++;
		if (crst === 1'b1)
			n_crst++;
	end
	icsr_top i_icsr_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hreg_we_i(we),
		.hreg_sel_i(sel), .hreg_wdata_i(wd), .bank_cfg_i(banks), .sb_req_i(sb_req),
		.sb_reqd_i(sb_reqd), .received_csr_request_irq_i(irq), .bus_reset_i(brst),
		.selfid_done_i(sid), .is_root_i(root), .cycle_master_control_i(cmc),
		.rom_rdata_i({24'h3c5a96, rom_addr}), .cmd_reg_o(cmd), .data_reg_o(dat),
		.swap_value_field_o(swp), .node_state_image_o(st), .rom_addr_o(rom_addr),
		.sb_ready_o(sb_ready), .sb_ack_o(sb_ack), .sb_rcode_o(rc), .sb_rdata_o(sb_rdata),
		.linkoff_flag_o(lof), .cmstr_flag_o(cmf), .command_reset_irq_o(crst));
	icsr_host_bfm i_icsr_host_bfm (.mclk_i(mclk_i), .cmd_reg_i(cmd), .hreg_we_o(we),
		.hreg_sel_o(sel), .hreg_wdata_o(wd));
	// ==========
	// Compare and access tasks
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t value %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t bits %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] cw(input logic [2:0] op, input logic core,
		input logic [1:0] bk, input logic [11:0] off, input logic [3:0] len);
		return {9'h0, len, off, bk, core, 1'b0, op};
	endfunction
	task automatic hchk(input logic [31:0] d, input logic [31:0] w, input logic [3:0] ef,
		input logic [31:0] ed);
		i_icsr_host_bfm.put(2'h1, d);
		i_icsr_host_bfm.issue(w, ok);
		chk_bits({3'h0, ok}, 4'h1);
		chk_bits({2'h0, dat.access_error_flag, dat.read_data_received_flag}, ef);
		chk_val(dat.access_data_field, ed);
	endtask
	task automatic sb(input icsr_pkg::icsr_op_t op, input logic [27:0] lo,
		input logic [7:0] len, input logic [31:0] a);
		int n;
		for (n = 0; n < 20 && sb_ready !== 1'b1; n++)
			@(negedge mclk_i);
		sb_req = 1'b1;
		sb_reqd = {op, 20'hfffff, lo, len, ~a, a};
		@(negedge mclk_i);
		sb_req = 1'b0;
		sb_reqd = ~sb_reqd;
		for (n = 0; n < 20 && sb_ack !== 1'b1; n++)
		begin
			@(posedge mclk_i);
			#1;
		end
		chk_bits({3'h0, sb_ack}, 4'h1);
		@(negedge mclk_i);
	endtask
	task automatic tally_and_finish();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#100us;
		n_fail++;
		tally_and_finish();
	end
	// ==========
	// Main sequence
	initial
	begin
		banks[0] = {28'h0001000, 6'h08, 3'h0};
		banks[1] = {28'h0002000, 6'h08, 3'h6};
		banks[2] = {28'h0003000, 6'h00, 3'h7};
		// Overlaps the core area on purpose
		banks[3] = {28'h0000000, 6'h04, 3'h7};
		repeat (8) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		@(negedge mclk_i);
		chk_val(st, 32'h0);
		hchk(32'ha5c30f1e, cw(3'h1, 1'b0, 2'h0, 12'h004, 4'h0), 4'h0, 32'ha5c30f1e);
		hchk(32'h600dbeef, cw(3'h1, 1'b0, 2'h1, 12'h000, 4'h0), 4'h0, 32'h600dbeef);
		hchk(32'h0, cw(3'h2, 1'b0, 2'h0, 12'h004, 4'h8), 4'h1, 32'ha5c30f1e);
		sb(icsr_pkg::OP_READ, 28'h0002000, 8'h0, 32'h0);
		chk_val(sb_rdata, 32'h600dbeef);
		sb(icsr_pkg::OP_READ, 28'h0001004, 8'h0, 32'h0);
		chk_bits({2'h0, rc}, {2'h0, icsr_pkg::RC_TYPE_ERR});
		sb(icsr_pkg::OP_WRITE, 28'h0002004, 8'h09, 32'h1);
		chk_bits({2'h0, rc}, {2'h0, icsr_pkg::RC_TYPE_ERR});
		sb(icsr_pkg::OP_READ, 28'h0003000, 8'h0, 32'h0);
		chk_bits({2'h0, rc}, {2'h0, icsr_pkg::RC_ADDR_ERR});
		hchk(32'h12345678, cw(3'h1, 1'b1, 2'h0, 12'h400, 4'h0), 4'h2, 32'h12345678);
		hchk(32'h0, cw(3'h2, 1'b1, 2'h0, 12'h408, 4'h0), 4'h1, 32'h3c5a9602);
		hchk(32'h0, cw(3'h2, 1'b1, 2'h0, 12'h408, 4'h1), 4'h2, 32'h0);
		hchk(32'h0, cw(3'h2, 1'b0, 2'h0, 12'h004, 4'h9), 4'h2, 32'h0);
		i_icsr_host_bfm.put(2'h2, 32'h0badcafe);
		chk_val(swp, 32'h0badcafe);
		hchk(32'ha5c30f1e, cw(3'h4, 1'b0, 2'h0, 12'h004, 4'h0), 4'h1, 32'ha5c30f1e);
		hchk(32'ha5c30f1e, cw(3'h4, 1'b0, 2'h0, 12'h004, 4'h0), 4'h3, 32'h0badcafe);
		hchk(32'h0, cw(3'h2, 1'b0, 2'h0, 12'h004, 4'h0), 4'h1, 32'h0badcafe);
		hchk(32'h0, cw(3'h4, 1'b1, 2'h0, 12'h400, 4'h0), 4'h2, 32'h0);
		hchk(32'h203, cw(3'h1, 1'b1, 2'h0, 12'h004, 4'h0), 4'h0, 32'h203);
		chk_val(st, 32'h200);
		hchk(32'h200, cw(3'h1, 1'b1, 2'h0, 12'h000, 4'h0), 4'h0, 32'h200);
		chk_val(st, 32'h0);
		brst = 1'b1;
		@(negedge mclk_i);
		brst = 1'b0;
		@(negedge mclk_i);
		chk_val(st, 32'h8001);
		sid = 1'b1;
		@(negedge mclk_i);
		sid = 1'b0;
		@(negedge mclk_i);
		chk_val(st, 32'h8000);
		root = 1'b1;
		cmc = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk_val(st, 32'h8100);
		root = 1'b0;
		repeat (2) @(negedge mclk_i);
		chk_val(st, 32'h8000);
		sb(icsr_pkg::OP_WRITE, 28'h0000004, 8'h0, 32'h300);
		chk_val(st, 32'h8200);
		sb(icsr_pkg::OP_WRITE, 28'h0000000, 8'h0, 32'h8000);
		chk_val(st, 32'h200);
		sb(icsr_pkg::OP_WRITE, 28'h000000c, 8'h0, 32'h0);
		chk_val(st, 32'h8200);
		sb(icsr_pkg::OP_READ, 28'h0000000, 8'h0, 32'h0);
		chk_val(sb_rdata, 32'h8200);
		chk_val(n_lof, 32'h2);
		chk_val(n_cmf, 32'h1);
		chk_val(n_crst, 32'h1);
		irq = 1'b1;
		i_icsr_host_bfm.put(2'h0, cw(3'h2, 1'b1, 2'h0, 12'h000, 4'h0));
		sb(icsr_pkg::OP_WRITE, 28'h0002008, 8'h0, 32'h7e57d00d);
		repeat (2) @(negedge mclk_i);
		chk_bits({2'h0, cmd.busy, cmd.read}, 4'h2);
		irq = 1'b0;
		hchk(32'h0, cw(3'h2, 1'b1, 2'h0, 12'h000, 4'h0), 4'h1, 32'h8200);
		hchk(32'h0, cw(3'h2, 1'b0, 2'h1, 12'h008, 4'h0), 4'h1, 32'h7e57d00d);
		tally_and_finish();
	end
endmodule // icsr_top_tb

bind icsr_top icsr_top_sva i_icsr_top_sva (.mclk_i, .sys_rst_i, .hreg_we_i, .hreg_sel_i,
	.hreg_wdata_i, .sb_req_i, .bus_reset_i, .selfid_done_i, .is_root_i,
	.cycle_master_control_i, .cmd_reg_o, .data_reg_o, .node_state_image_o, .sb_ready_o,
	.sb_ack_o, .linkoff_flag_o, .command_reset_irq_o);
